// >>> shared/sck_cfg.svh
`ifndef SCK_CFG_SVH
`define SCK_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SCK_ADDR_CTRL 8'h00
`define SCK_ADDR_DV_LIM 8'h04
`define SCK_ADDR_DF_LIM 8'h08
`define SCK_ADDR_DPH_LIM 8'h0C
`define SCK_ADDR_CB_TIME 8'h10
`define SCK_ADDR_RATIO 8'h14
`define SCK_ADDR_ANG_CORR 8'h18
`define SCK_ADDR_LEVELS 8'h1C
`define SCK_ADDR_STATUS 8'h20
`define SCK_ADDR_DELTA 8'h24

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SCK_CTRL_ENABLE 0
`define SCK_CTRL_MODE 1
`define SCK_CTRL_SUP_MAN 2
`define SCK_CTRL_SUP_AUTO 3
`define SCK_CTRL_LIVE_BUS_DEAD_LINE_OVERRIDE 4
`define SCK_CTRL_DEAD_BUS_LIVE_LINE_OVERRIDE 5
`define SCK_CTRL_DEAD_BUS_DEAD_LINE_OVERRIDE 6
`define SCK_CTRL_XFMR 7
`define SCK_CTRL_PH_PH 8
`define SCK_CTRL_SEL_LO 9
`define SCK_CTRL_SEL_HI 10
`define SCK_CTRL_W 11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCK_RST_CTRL 11'h002
`define SCK_RST_DV_LIM 16'h0800
`define SCK_RST_DF_LIM 16'h1000
`define SCK_RST_DPH_LIM 16'h0200
`define SCK_RST_CB_TIME 16'h0050
`define SCK_RST_RATIO 16'h0100
`define SCK_RST_ANG_CORR 16'h0000
`define SCK_RST_DEAD 16'h0800
`define SCK_RST_LIVE 16'h3000

// ----------------------------------------
// Fixed-point scaling and AXI response codes
// ----------------------------------------
`define SCK_RATIO_FRAC 8
`define SCK_TIME_FRAC 10
`define SCK_RESP_OKAY 2'h0
`define SCK_RESP_SLVERR 2'h2

`endif

// >>> shared/sck_pkg.sv
package sck_pkg;

    typedef enum logic {
        sck_machine_to_grid_mode = 1'b0,
        sck_grid_to_grid_mode = 1'b1
    } sck_pairing_mode_t;

endpackage

// >>> testbench/sck_breaker_model.sv
// ----------------------------------------
// Breaker control and bypass source
// ----------------------------------------
module sck_breaker_model (
    input wire logic aclk,
    input wire logic want_manual,
    input wire logic want_auto,
    input wire logic want_bypass,
    input wire logic [3:0] lag,
    output logic manual_close_req,
    output logic auto_close_req,
    output logic bypass_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] pend = 3'h0;
    logic [3:0] wait_cnt = 4'h0;

    initial begin
        manual_close_req = 1'b0;
        auto_close_req = 1'b0;
        bypass_in = 1'b0;
    end

    // A new wish waits lag cycles, so the pins can answer promptly or slowly
    always @(posedge aclk) begin
        if ({want_manual, want_auto, want_bypass} !== pend) begin
            pend <= {want_manual, want_auto, want_bypass};
            wait_cnt <= lag;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else begin
            manual_close_req <= pend[2];
            auto_close_req <= pend[1];
            bypass_in <= pend[0];
        end
    end
endmodule

// >>> testbench/tb_synchrocheck_close_release.sv
`include "sck_cfg.svh"

module tb_synchrocheck_close_release;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp; logic rd;} sck_note_t;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] bus_mag_1 = 16'h0, bus_mag_2 = 16'h0, bus_mag_3 = 16'h0;
    logic [15:0] bus_ang_1 = 16'h0, bus_ang_2 = 16'h0, bus_ang_3 = 16'h0, line_ang = 16'h0;
    logic [15:0] line_side_voltage_input = 16'h0, bus_frequency = 16'h0, line_frequency = 16'h0;
    logic manual_close_req, auto_close_req, bypass_in, close_permit, close_release, sync_ok;
    logic want_man = 1'b0, want_auto = 1'b0, want_byp = 1'b0;
    logic [3:0] lag = 4'h0;
    int fails = 0, cmp_count = 0;
    sck_note_t notes[$];
    sck_note_t n;
    logic [33:0] got;
    logic [31:0] rst_tab [8];
    logic [47:0] lim_tab [12];
    logic [15:0] m, d, ad;

    always #10 aclk = ~aclk;

    sck_close_release dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_mag_1, .bus_mag_2, .bus_mag_3,
        .bus_ang_1, .bus_ang_2, .bus_ang_3, .line_side_voltage_input, .line_ang,
        .bus_frequency, .line_frequency, .manual_close_req, .auto_close_req, .bypass_in,
        .close_permit, .close_release, .sync_ok);

    sck_breaker_model breaker (.aclk, .want_manual(want_man), .want_auto,
        .want_bypass(want_byp), .lag, .manual_close_req, .auto_close_req, .bypass_in);

    // ----------------------------------------
    // Bus master, stimulus and result watcher
    // ----------------------------------------
    task automatic put(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] r);
        logic aw_done;
        logic w_done;
        notes.push_back('{32'h0, 32'h0, r, 1'b0});
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dv;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] dv, mk, input logic [1:0] r);
        notes.push_back('{dv, mk, r, 1'b1});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic meas(input logic [15:0] bm, lm, ba, la, fb, fl);
        bus_mag_1 <= bm;
        bus_mag_2 <= bm;
        bus_mag_3 <= bm;
        bus_ang_1 <= ba;
        bus_ang_2 <= ba;
        bus_ang_3 <= ba;
        line_side_voltage_input <= lm;
        line_ang <= la;
        bus_frequency <= fb;
        line_frequency <= fl;
        repeat (6) @(posedge aclk);
    endtask

    task automatic req(input logic mr, ar, br);
        want_man <= mr;
        want_auto <= ar;
        want_byp <= br;
        repeat (12) @(posedge aclk);
    endtask

    task automatic chk(input logic s, p, r);
        repeat (2) @(posedge aclk);
        cmp_count++;
        if ({close_release, close_permit, sync_ok} !== {r, p, s}) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time,
                {close_release, close_permit, sync_ok}, {r, p, s});
        end
        get(`SCK_ADDR_STATUS, {21'h0, r, p, 8'h00, s}, 32'h0000_0601, `SCK_RESP_OKAY);
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
            n = notes.pop_front();
            got = n.rd ? {s_axi_rresp, s_axi_rdata & n.mask} : {s_axi_bresp, 32'h0};
            cmp_count++;
            if (got !== {n.resp, n.data & n.mask}) begin
                fails++;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, {n.resp, n.data & n.mask});
            end
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        int i;
        int k;
        void'($urandom(32'hB2AB));
        rst_tab = '{{21'h0, `SCK_RST_CTRL}, {16'h0, `SCK_RST_DV_LIM}, {16'h0, `SCK_RST_DF_LIM},
            {16'h0, `SCK_RST_DPH_LIM}, {16'h0, `SCK_RST_CB_TIME}, {16'h0, `SCK_RST_RATIO},
            {16'h0, `SCK_RST_ANG_CORR}, {`SCK_RST_LIVE, `SCK_RST_DEAD}};
        lim_tab = '{48'h4800_1000_8000, 48'h4801_1000_8000, 48'h3800_1000_8000,
            48'h37FF_1000_8000, 48'h4000_1000_7000, 48'h4000_1000_6FFF, 48'h4000_1000_9000,
            48'h4000_1000_9001, 48'h4000_1200_8000, 48'h4000_1201_8000, 48'h4000_0E00_8000,
            48'h4000_0DFF_8000};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 8; i++) begin
            get(8'(4 * i), rst_tab[i], 32'hFFFF_FFFF, `SCK_RESP_OKAY);
        end
        get(8'h28, 32'h0, 32'hFFFF_FFFF, `SCK_RESP_SLVERR);
        put(8'h28, 32'h0000_0001, `SCK_RESP_SLVERR);
        put(`SCK_ADDR_STATUS, 32'h0000_FFFF, `SCK_RESP_SLVERR);
        $display("TEST registers done");
        put(`SCK_ADDR_CTRL, 32'h0000_010F, `SCK_RESP_OKAY);
        get(`SCK_ADDR_CTRL, 32'h0000_010F, 32'hFFFF_FFFF, `SCK_RESP_OKAY);
        meas(16'h4000, 16'h4000, 16'h1000, 16'h1000, 16'h8000, 16'h8000);
        req(1'b1, 1'b0, 1'b0);
        chk(1'b1, 1'b1, 1'b1);
        req(1'b0, 1'b0, 1'b0);
        for (i = 0; i < 12; i++) begin
            meas(16'h4000, lim_tab[i][47:32], 16'h1000, lim_tab[i][31:16], 16'h8000,
                lim_tab[i][15:0]);
            chk(i % 2 == 0, i % 2 == 0, 1'b0);
        end
        for (i = 0; i < 4; i++) begin
            put(`SCK_ADDR_CTRL, 32'h0000_000F | (32'(i) << 9), `SCK_RESP_OKAY);
            meas(16'h4000, i == 1 ? 16'h5000 : i == 2 ? 16'h6000 : 16'h4000, 16'h1000,
                16'h1000, 16'h8000, 16'h8000);
            bus_mag_2 <= 16'h5000;
            bus_mag_3 <= 16'h6000;
            chk(1'b1, 1'b1, 1'b0);
        end
        $display("TEST limits and phase select done");
        put(`SCK_ADDR_CTRL, 32'h0000_000D, `SCK_RESP_OKAY);
        meas(16'h4000, 16'h4000, 16'h0DEC, 16'h1000, 16'h8100, 16'h8000);
        chk(1'b1, 1'b1, 1'b0);
        put(`SCK_ADDR_CTRL, 32'h0000_000F, `SCK_RESP_OKAY);
        chk(1'b0, 1'b0, 1'b0);
        $display("TEST closing lead done");
        for (k = 0; k < 3; k++) begin
            meas(k == 0 ? 16'h4000 : 16'h0100, k == 1 ? 16'h4000 : 16'h0100, 16'h1000,
                16'h5000, 16'h8000, 16'h8000);
            put(`SCK_ADDR_CTRL, 32'h0000_007F & ~(32'h1 << (4 + k)), `SCK_RESP_OKAY);
            chk(1'b0, 1'b0, 1'b0);
            put(`SCK_ADDR_CTRL, 32'h0000_000F | (32'h1 << (4 + k)), `SCK_RESP_OKAY);
            chk(1'b0, 1'b1, 1'b0);
        end
        put(`SCK_ADDR_CTRL, 32'h0000_000F, `SCK_RESP_OKAY);
        lag <= 4'h3;
        req(1'b0, 1'b0, 1'b1);
        chk(1'b0, 1'b1, 1'b1);
        req(1'b0, 1'b0, 1'b0);
        chk(1'b0, 1'b0, 1'b0);
        lag <= 4'h0;
        $display("TEST overrides and bypass done");
        for (i = 0; i < 8; i++) begin
            put(`SCK_ADDR_CTRL, 32'h0000_0003 | (32'(i >> 1) << 2), `SCK_RESP_OKAY);
            req(i % 2 == 0, i % 2 == 1, 1'b0);
            chk(1'b0, 1'b0, ((i >> (1 + i % 2)) & 1) == 0);
        end
        put(`SCK_ADDR_CTRL, 32'h0000_000E, `SCK_RESP_OKAY);
        req(1'b1, 1'b0, 1'b0);
        get(`SCK_ADDR_STATUS, 32'h0000_0400, 32'h0000_0400, `SCK_RESP_OKAY);
        req(1'b0, 1'b0, 1'b0);
        $display("TEST supervision done");
        put(`SCK_ADDR_RATIO, 32'h0000_0080, `SCK_RESP_OKAY);
        put(`SCK_ADDR_ANG_CORR, 32'h0000_4000, `SCK_RESP_OKAY);
        put(`SCK_ADDR_CTRL, 32'h0000_008F, `SCK_RESP_OKAY);
        meas(16'h4000, 16'h2000, 16'h1000, 16'h5000, 16'h8000, 16'h8000);
        chk(1'b1, 1'b1, 1'b0);
        put(`SCK_ADDR_CTRL, 32'h0000_000F, `SCK_RESP_OKAY);
        chk(1'b0, 1'b0, 1'b0);
        put(`SCK_ADDR_ANG_CORR, 32'h0000_C000, `SCK_RESP_OKAY);
        put(`SCK_ADDR_CTRL, 32'h0000_008F, `SCK_RESP_OKAY);
        meas(16'h4000, 16'h2000, 16'h1000, 16'hD000, 16'h8000, 16'h8000);
        chk(1'b1, 1'b1, 1'b0);
        $display("TEST transformer done");
        put(`SCK_ADDR_CTRL, 32'h0000_000F, `SCK_RESP_OKAY);
        for (i = 0; i < 8; i++) begin
            m = 16'($urandom_range(16'h4000, 16'h8000));
            d = 16'($urandom_range(0, 16'h1400));
            ad = d >= 16'h0800 ? d - 16'h0800 : 16'h0800 - d;
            meas(m, m + d - 16'h0800, 16'h1000, 16'h1000, 16'h8000, 16'h8000);
            chk(ad <= 16'h0800, ad <= 16'h0800, 1'b0);
            get(`SCK_ADDR_DELTA, {16'h0, ad}, 32'hFFFF_FFFF, `SCK_RESP_OKAY);
        end
        $display("TEST random magnitudes done");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        close_out();
    end
endmodule

// >>> verilog/sck_close_release.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`include "sck_cfg.svh"

// Notes on behaviour
// - Inputs one to three are bus; fourth is line, compared to selected phase.
// - Bus may be wired as phase-to-neutral or phase-to-phase quantities.
// - Evaluate magnitude, phase angle and frequency differences between bus and line.
// - When enabled, supervise manual, automatic, or both close request kinds.
// - Slip frequency is absolute bus frequency minus line frequency.
// - Synchronous only when all three differences are within limits together.
// - Machine mode leads release by closing time so contacts meet at zero angle.
// - Grid mode uses the same three checks without closing-time lead.
// - Enabled overrides give close permit for live/dead, dead/live, dead/dead bus and line.
// - While external bypass is high, skip checking and give close release.
// - Transformer mode compensates magnitude by line-to-bus voltage ratio.
// - Transformer mode shifts angle comparison by configured line-minus-bus offset.
module sck_close_release
    import sck_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] bus_mag_1,
    input wire logic [15:0] bus_mag_2,
    input wire logic [15:0] bus_mag_3,
    input wire logic [15:0] bus_ang_1,
    input wire logic [15:0] bus_ang_2,
    input wire logic [15:0] bus_ang_3,
    input wire logic [15:0] line_side_voltage_input,
    input wire logic [15:0] line_ang,
    input wire logic [15:0] bus_frequency,
    input wire logic [15:0] line_frequency,
    input wire logic manual_close_req,
    input wire logic auto_close_req,
    input wire logic bypass_in,
    output logic close_permit,
    output logic close_release,
    output logic sync_ok
);

    if (ADDR_W < 8) begin : g_addr_check
        $error("sck_close_release: ADDR_W too small for the register map");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [`SCK_CTRL_W-1:0] ctrl;
    logic [15:0] magnitude_delta_limit;
    logic [15:0] freq_delta_limit;
    logic [15:0] phase_delta_limit;
    logic [15:0] cb_time;
    logic [15:0] ratio;
    logic [15:0] ang_corr;
    logic [15:0] dead_level;
    logic [15:0] live_level;
    logic [15:0] dv_q;
    logic [15:0] dphi_q;
    logic [7:0] flags;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] pins_s;

    sck_pin_sync #(.WIDTH(3)) u_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({bypass_in, auto_close_req, manual_close_req}),
        .pin_sync(pins_s)
    );

    wire man_s = pins_s[0];
    wire auto_s = pins_s[1];
    wire bypass_s = pins_s[2];

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    wire enable = ctrl[`SCK_CTRL_ENABLE];
    sck_pairing_mode_t pairing_mode_select;
    assign pairing_mode_select = sck_pairing_mode_t'(ctrl[`SCK_CTRL_MODE]);
    wire xfmr = ctrl[`SCK_CTRL_XFMR];
    wire [1:0] sel = ctrl[`SCK_CTRL_SEL_HI:`SCK_CTRL_SEL_LO];
    wire live_bus_dead_line_override = ctrl[`SCK_CTRL_LIVE_BUS_DEAD_LINE_OVERRIDE];
    wire dead_bus_live_line_override = ctrl[`SCK_CTRL_DEAD_BUS_LIVE_LINE_OVERRIDE];
    wire dead_bus_dead_line_override = ctrl[`SCK_CTRL_DEAD_BUS_DEAD_LINE_OVERRIDE];

    // ----------------------------------------
    // Measurement path
    // ----------------------------------------
    // Channel meaning (L1 or L1-L2 ...) follows the wiring bit; the math is the same
    wire [15:0] ref_mag = (sel == 2'h1) ? bus_mag_2 :
                          (sel == 2'h2) ? bus_mag_3 : bus_mag_1;
    wire [15:0] ref_ang = (sel == 2'h1) ? bus_ang_2 :
                          (sel == 2'h2) ? bus_ang_3 : bus_ang_1;

    // Magnitude compared in line units: |line - bus*k| <= lim*k is |line/k - bus| <= lim
    wire [15:0] k_eff = xfmr ? ratio : `SCK_RST_RATIO;
    wire [31:0] bus_scaled_w = ref_mag * k_eff;
    wire [31:0] lim_scaled_w = magnitude_delta_limit * k_eff;
    wire [23:0] bus_scaled = bus_scaled_w[`SCK_RATIO_FRAC +: 24];
    wire [23:0] lim_scaled = lim_scaled_w[`SCK_RATIO_FRAC +: 24];
    wire [23:0] line_ext = {8'h00, line_side_voltage_input};
    wire [23:0] dv_w = (line_ext > bus_scaled) ? line_ext - bus_scaled
                                               : bus_scaled - line_ext;
    wire dv_ok = dv_w <= lim_scaled;

    wire [15:0] line_ang_c = xfmr ? line_ang - ang_corr : line_ang;
    wire [15:0] dphi_raw = ref_ang - line_ang_c;

    wire signed [16:0] slip_s = $signed({1'b0, bus_frequency})
                              - $signed({1'b0, line_frequency});
    wire [16:0] slip_abs = slip_s[16] ? 17'(-slip_s) : 17'(slip_s);
    wire df_ok = slip_abs <= {1'b0, freq_delta_limit};

    // Angle travelled during breaker closing time, in 1/65536 turn
    wire signed [33:0] lead_w = slip_s * $signed({1'b0, cb_time});
    wire signed [33:0] lead_sh = lead_w >>> `SCK_TIME_FRAC;
    wire [15:0] lead = (pairing_mode_select == sck_machine_to_grid_mode)
                     ? lead_sh[15:0] : 16'h0000;
    wire [15:0] dphi_pred = dphi_raw + lead;
    wire [15:0] dphi_abs = dphi_pred[15] ? 16'(-dphi_pred) : dphi_pred;
    wire dphi_ok = dphi_abs <= phase_delta_limit;

    wire next_sync = dv_ok && df_ok && dphi_ok;

    wire bus_live = ref_mag >= live_level;
    wire bus_dead = ref_mag <= dead_level;
    wire line_live = line_side_voltage_input >= live_level;
    wire line_dead = line_side_voltage_input <= dead_level;
    wire ovr_ok = (live_bus_dead_line_override && bus_live && line_dead)
               || (dead_bus_live_line_override && bus_dead && line_live)
               || (dead_bus_dead_line_override && bus_dead && line_dead);

    wire next_permit = bypass_s || next_sync || ovr_ok;
    wire man_ok = !(enable && ctrl[`SCK_CTRL_SUP_MAN]) || next_permit;
    wire auto_ok = !(enable && ctrl[`SCK_CTRL_SUP_AUTO]) || next_permit;
    wire next_release = bypass_s || (man_s && man_ok) || (auto_s && auto_ok);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_ok <= 1'b0;
            close_permit <= 1'b0;
            close_release <= 1'b0;
            dv_q <= 16'h0000;
            dphi_q <= 16'h0000;
            flags <= 8'h00;
        end else begin
            sync_ok <= next_sync;
            close_permit <= next_permit;
            close_release <= next_release;
            dv_q <= (dv_w[23:16] != 8'h00) ? 16'hFFFF : dv_w[15:0];
            dphi_q <= dphi_abs;
            flags <= {bypass_s, ovr_ok, line_dead, line_live,
                      bus_dead, bus_live, dphi_ok, df_ok};
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire wr_do = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    wire rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire w_hit = (wa <= `SCK_ADDR_LEVELS);
    wire r_hit = (ra <= `SCK_ADDR_DELTA);
    wire [31:0] ctrl_w = {21'h0, ctrl};
    wire [31:0] levels_w = {live_level, dead_level};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] wm_ctrl = merge(ctrl_w, s_axi_wdata, s_axi_wstrb);
    wire [31:0] wm_lev = merge(levels_w, s_axi_wdata, s_axi_wstrb);
    wire [31:0] wm_16 = merge(32'h0, s_axi_wdata, s_axi_wstrb);
    wire lo_keep = !s_axi_wstrb[0];
    wire hi_keep = !s_axi_wstrb[1];

    function automatic logic [15:0] m16(input logic [15:0] old, input logic [31:0] nw,
                                        input logic lo_k, input logic hi_k);
        return {hi_k ? old[15:8] : nw[15:8], lo_k ? old[7:0] : nw[7:0]};
    endfunction

    wire [31:0] rd_mux =
        (ra == `SCK_ADDR_CTRL) ? ctrl_w :
        (ra == `SCK_ADDR_DV_LIM) ? {16'h0, magnitude_delta_limit} :
        (ra == `SCK_ADDR_DF_LIM) ? {16'h0, freq_delta_limit} :
        (ra == `SCK_ADDR_DPH_LIM) ? {16'h0, phase_delta_limit} :
        (ra == `SCK_ADDR_CB_TIME) ? {16'h0, cb_time} :
        (ra == `SCK_ADDR_RATIO) ? {16'h0, ratio} :
        (ra == `SCK_ADDR_ANG_CORR) ? {16'h0, ang_corr} :
        (ra == `SCK_ADDR_LEVELS) ? levels_w :
        (ra == `SCK_ADDR_STATUS) ? {21'h0, close_release, close_permit, flags, sync_ok} :
        (ra == `SCK_ADDR_DELTA) ? {dphi_q, dv_q} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCK_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? `SCK_RESP_OKAY : `SCK_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SCK_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= r_hit ? `SCK_RESP_OKAY : `SCK_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `SCK_RST_CTRL;
            magnitude_delta_limit <= `SCK_RST_DV_LIM;
            freq_delta_limit <= `SCK_RST_DF_LIM;
            phase_delta_limit <= `SCK_RST_DPH_LIM;
            cb_time <= `SCK_RST_CB_TIME;
            ratio <= `SCK_RST_RATIO;
            ang_corr <= `SCK_RST_ANG_CORR;
            dead_level <= `SCK_RST_DEAD;
            live_level <= `SCK_RST_LIVE;
        end else if (wr_do) begin
            unique case (wa)
                `SCK_ADDR_CTRL: ctrl <= wm_ctrl[`SCK_CTRL_W-1:0];
                `SCK_ADDR_DV_LIM: magnitude_delta_limit <=
                    m16(magnitude_delta_limit, wm_16, lo_keep, hi_keep);
                `SCK_ADDR_DF_LIM: freq_delta_limit <=
                    m16(freq_delta_limit, wm_16, lo_keep, hi_keep);
                `SCK_ADDR_DPH_LIM: phase_delta_limit <=
                    m16(phase_delta_limit, wm_16, lo_keep, hi_keep);
                `SCK_ADDR_CB_TIME: cb_time <= m16(cb_time, wm_16, lo_keep, hi_keep);
                `SCK_ADDR_RATIO: ratio <= m16(ratio, wm_16, lo_keep, hi_keep);
                `SCK_ADDR_ANG_CORR: ang_corr <= m16(ang_corr, wm_16, lo_keep, hi_keep);
                `SCK_ADDR_LEVELS: begin
                    dead_level <= wm_lev[15:0];
                    live_level <= wm_lev[31:16];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    bypass_release_a: assert property (bypass_s |=> close_release && close_permit)
        else $error("bypass did not give close release");
    sync_all_a: assert property (sync_ok |-> $past(dv_ok && df_ok && dphi_ok))
        else $error("sync flagged with a limit exceeded");
    slip_abs_a: assert property (slip_abs == ((bus_frequency >= line_frequency)
        ? {1'b0, 16'(bus_frequency - line_frequency)}
        : {1'b0, 16'(line_frequency - bus_frequency)}))
        else $error("slip is not the absolute frequency difference");
    grid_nolead_a: assert property (pairing_mode_select == sck_grid_to_grid_mode
        |-> dphi_pred == dphi_raw)
        else $error("lead applied in grid mode");
    machine_lead_a: assert property (pairing_mode_select == sck_machine_to_grid_mode
        && (cb_time == 16'h0000 || bus_frequency == line_frequency) |-> dphi_pred == dphi_raw)
        else $error("lead present with zero closing time or zero slip");
    xfmr_off_a: assert property (!xfmr |-> line_ang_c == line_ang && k_eff == 16'h0100)
        else $error("corrections active outside transformer mode");
    xfmr_ang_a: assert property (xfmr |-> 16'(line_ang_c + ang_corr) == line_ang)
        else $error("angle offset not applied");
    dead_ovr_a: assert property (dead_bus_dead_line_override && bus_dead && line_dead
        |=> close_permit)
        else $error("dead bus dead line override ignored");
    man_block_a: assert property (enable && ctrl[`SCK_CTRL_SUP_MAN] && !auto_s
        && !next_permit |=> !close_release)
        else $error("supervised manual close released without permit");
    ref_sel_a: assert property (sel == 2'h1 |-> ref_mag == bus_mag_2)
        else $error("wrong bus phase selected");
    ratio_a: assert property (xfmr |-> k_eff == ratio)
        else $error("ratio not applied in transformer mode");
    wr_resp_a: assert property (wr_do |=> s_axi_bvalid)
        else $error("write response missing");

    sync_seen_c: cover property (sync_ok ##1 close_release);
    ovr_seen_c: cover property (!sync_ok && close_permit && !bypass_s);
    xfmr_sync_c: cover property (xfmr && sync_ok);
    lead_c: cover property (pairing_mode_select == sck_machine_to_grid_mode
        && dphi_pred != dphi_raw && next_sync);

endmodule

// >>> verilog/sck_pin_sync.sv
module sck_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_width_check
        $error("sck_pin_sync: WIDTH must be at least 1");
    end

    // ----------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            pin_sync <= '0;
        end else begin
            stage1 <= pin_in;
            pin_sync <= stage1;
        end
    end

endmodule
